//--- dv/lps_rx_model.sv
// receiver model: frames the four data lanes on the forwarded clock pattern
`timescale 1ns/1ps
module lps_rx_model
  import lps_pkg::*;
(
  input  wire logic              clk,     // bit clock
  input  wire logic [LANES-1:0]  lane_p,  // data lanes, true side
  input  wire logic              lane_oe, // data lanes driven
  input  wire logic              fwd_p,   // forwarded clock, true side
  input  wire logic              fwd_oe,  // forwarded clock driven
  output logic      [WORD_W-1:0] rx_word, // last seven bits of each lane, a framed word only when rx_stb is high
  output logic                   rx_stb   // high for one cycle when a frame closes
);
  //////////////////////////////////////////////////////////////////////////////
  logic [6:0]            clk_hist_reg;
  logic [6:0]            lane_hist_reg [LANES];
  // a released pair reads low at the termination, never the last value
  wire logic [LANES-1:0] lane_seen = lane_oe ? lane_p : {LANES{1'b0}};
  wire logic             fwd_seen  = fwd_oe & fwd_p;

  // oldest bit ends in position 0, so bit s is slot s after seven shifts
  always_ff @(posedge clk) begin
    clk_hist_reg <= {fwd_seen, clk_hist_reg[6:1]};
    for (int k = 0; k < LANES; k++) begin
      lane_hist_reg[k] <= {lane_seen[k], lane_hist_reg[k][6:1]};
    end
  end

  // all rotations of the pattern differ, so only the true boundary matches
  assign rx_stb = (clk_hist_reg === CLK_PATTERN);
  for (genvar k = 0; k < LANES; k++) begin : g_lane
    assign rx_word[BITS_PER_LANE*k +: BITS_PER_LANE] = lane_hist_reg[k];
  end
endmodule : lps_rx_model

//--- dv/lvds_pixel_serializer_test.sv
// self-checking bench for the pixel serializer
`timescale 1ns/1ps
module lvds_pixel_serializer_test;
  import lps_pkg::*;
  localparam int LOCK_MAX = 200;
  logic              clk, sys_rst, pix_clk, pix_run, spread, sel, sleep_n;
  logic [WORD_W-1:0] word_hi, word_lo, pix_word, rx_word;
  logic [LANES-1:0]  dp, dn;
  logic              doe, cp, cn, coe, locked, rx_stb;
  int                n_mismatch, checks_done;

  //////////////////////////////////////////////////////////////////////////////
  lps_top #(.LOCK_MAX_CYCLES(LOCK_MAX)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .pixel_clock_input(pix_clk),
    .parallel_pixel_inputs(pix_word[COLOUR_W-1:0]), .line_sync(pix_word[LINE_SYNC_BIT]),
    .frame_sync(pix_word[FRAME_SYNC_BIT]), .pixel_valid(pix_word[PIXEL_VALID_BIT]),
    .spare_ctrl(pix_word[SPARE_CTRL_BIT]), .strobe_edge_select(sel),
    .sleep_request_n(sleep_n), .serial_data_pairs_p(dp), .serial_data_pairs_n(dn),
    .serial_data_oe(doe), .forwarded_clock_pair_p(cp), .forwarded_clock_pair_n(cn),
    .forwarded_clock_oe(coe), .pll_locked(locked));
  lps_rx_model i_rx (.clk(clk), .lane_p(dp), .lane_oe(doe), .fwd_p(cp), .fwd_oe(coe),
    .rx_word(rx_word), .rx_stb(rx_stb));

  // clocks; the pixel clock has its own phase and can stop or wander
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    pix_clk = 1'b0;
    #3.3;
    forever begin
      #(spread ? 15 + $urandom_range(2, 0) : 16);
      if (pix_run) pix_clk = ~pix_clk;
    end
  end
  // a different word in each half period tells the two strobe edges apart
  always @(pix_clk) #2 pix_word = pix_clk ? word_hi : word_lo;

  //////////////////////////////////////////////////////////////////////////////
  task automatic check_bit(string name, logic exp, logic got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check_bit

  task automatic check_word(string name, logic [WORD_W-1:0] exp, logic [WORD_W-1:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check_word

  task automatic report_and_stop;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  // inputs move just after the system clock edge
  task automatic cycles(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cycles

  // rising strobe takes the word of the low phase, falling that of the high phase
  function automatic logic [WORD_W-1:0] exp_word(logic s);
    return s ? word_lo : word_hi;
  endfunction : exp_word

  task automatic wait_lock;
    for (int i = 0; i < LOCK_MAX && locked !== 1'b1; i++) cycles(1);
    check_bit("pll_locked", 1'b1, locked);
  endtask : wait_lock

  // corner words first, random words after
  task automatic send_check(logic s, int idx);
    logic [WORD_W-1:0] corner [3];
    corner = '{28'h0000000, 28'hFFFFFFF, 28'hF000000};
    sel = s;
    word_hi = (idx < 3) ? corner[idx] : WORD_W'($urandom);
    word_lo = (idx < 3) ? ~corner[idx] : WORD_W'($urandom);
    cycles(60);
    for (int i = 0; i < 20 && rx_stb !== 1'b1; i++) cycles(1);
    check_bit("rx_stb", 1'b1, rx_stb);
    check_word("rx_word", exp_word(s), rx_word);
    check_word("lane_n", {24'h000000, ~dp}, {24'h000000, dn});
    check_bit("clk_n", ~cp, cn);
  endtask : send_check

  task automatic check_quiet(logic oe, logic lk);
    check_bit("serial_data_oe", oe, doe);
    check_bit("forwarded_clock_oe", oe, coe);
    check_bit("pll_locked", lk, locked);
    check_word("lanes_p", 28'h0000000, {24'h000000, dp});
  endtask : check_quiet

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end

  // main sequence
  initial begin
    void'($urandom(47));
    sys_rst = 1'b1;
    sleep_n = 1'b0;
    pix_run = 1'b1;
    spread = 1'b0;
    sel = 1'b0;
    word_hi = 28'h0000000;
    word_lo = 28'h0000000;
    cycles(5);
    check_quiet(1'b0, 1'b0);
    sys_rst = 1'b0;
    cycles(10);
    // clock stopped shortly before wake, then started only after wake
    pix_run = 1'b0;
    cycles(5);
    sleep_n = 1'b1;
    cycles(40);
    check_bit("pll_locked", 1'b0, locked);
    pix_run = 1'b1;
    wait_lock();
    for (int i = 0; i < 10; i++) send_check(i[0], i);
    // modulated pixel clock
    spread = 1'b1;
    for (int i = 0; i < 4; i++) send_check(i[0], 3 + i);
    spread = 1'b0;
    // sleep pulse once the clock is steady again
    sleep_n = 1'b0;
    cycles(SLEEP_ENTRY_CYCLES - 1);
    check_quiet(1'b0, 1'b0);
    check_bit("clk_p", 1'b0, cp);
    cycles(20);
    sleep_n = 1'b1;
    wait_lock();
    send_check(1'b1, 5);
    // stopped clock relocks without any sleep
    pix_run = 1'b0;
    cycles(40);
    check_quiet(1'b1, 1'b0);
    pix_run = 1'b1;
    wait_lock();
    send_check(1'b0, 6);
    report_and_stop();
  end
endmodule : lvds_pixel_serializer_test

//--- src/lps_pkg.sv
// constants shared by the pixel serializer design files
package lps_pkg;

  // word and lane layout
  localparam int WORD_W        = 28;
  localparam int COLOUR_W      = 24;
  localparam int LANES         = 4;
  localparam int BITS_PER_LANE = 7;
  localparam int LINE_SYNC_BIT   = 24;
  localparam int FRAME_SYNC_BIT  = 25;
  localparam int PIXEL_VALID_BIT = 26;
  localparam int SPARE_CTRL_BIT  = 27;

  // serial frame slots and the forwarded clock shape, sent from slot 0 upward
  localparam logic [2:0] SLOT_FIRST  = 3'h0;
  localparam logic [2:0] SLOT_LAST   = 3'h6;
  localparam logic [6:0] CLK_PATTERN = 7'h63;

  // timing, in the printed units and then in cycles of the 100 MHz clock
  localparam int CLK_PERIOD_NS         = 10;
  localparam int SLEEP_ENTRY_DELAY_NS  = 100;
  localparam int SLEEP_ENTRY_CYCLES    = SLEEP_ENTRY_DELAY_NS / CLK_PERIOD_NS;
  localparam int PLL_LOCK_TIME_MS      = 10;
  localparam int PLL_LOCK_MAX_CYCLES   = (PLL_LOCK_TIME_MS * 1000000) / CLK_PERIOD_NS;

  // clock activity monitor: gap that means the pixel clock has stopped
  localparam logic [4:0] MISS_CYCLES      = 5'h10;
  // run of live clock needed before the loop reports lock
  localparam logic [6:0] LOCK_QUAL_CYCLES = 7'h40;

  typedef enum logic [1:0] {ST_SLEEP, ST_ACQUIRE, ST_LOCKED} lps_state_t;

endpackage : lps_pkg

//--- src/lps_sync2.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module lps_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,   // destination clock
  input  wire logic         rst,   // synchronous reset, active high
  input  wire logic [W-1:0] d,     // level from another domain
  output logic      [W-1:0] q      // synchronised level
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      q_reg    <= '0;
    end else begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule : lps_sync2

//--- src/lps_top.sv
// pixel word serializer: capture, lock tracking, four data lanes and forwarded clock
`timescale 1ns/1ps
module lps_top
  import lps_pkg::*;
#(
  parameter int LOCK_MAX_CYCLES = PLL_LOCK_MAX_CYCLES
) (
  input  wire logic                clk,                    // system clock, 100 MHz
  input  wire logic                sys_rst,                // synchronous reset, high
  input  wire logic                pixel_clock_input,      // pixel clock from source
  input  wire logic [COLOUR_W-1:0] parallel_pixel_inputs,  // red, green, blue bits
  input  wire logic                line_sync,              // horizontal sync
  input  wire logic                frame_sync,             // vertical sync
  input  wire logic                pixel_valid,            // data enable
  input  wire logic                spare_ctrl,             // spare control line
  input  wire logic                strobe_edge_select,     // 1 rising, 0 falling
  input  wire logic                sleep_request_n,        // power-down, low active
  output logic      [LANES-1:0]    serial_data_pairs_p,    // data lanes, true side
  output logic      [LANES-1:0]    serial_data_pairs_n,    // data lanes, complement
  output logic                     serial_data_oe,         // data lanes driven
  output logic                     forwarded_clock_pair_p, // forwarded clock, true
  output logic                     forwarded_clock_pair_n, // forwarded clock, complement
  output logic                     forwarded_clock_oe,     // clock pair driven
  output logic                     pll_locked              // lock status
);
  logic              sleep_n_s;
  logic [WORD_W-1:0] cdc_word;
  logic              cdc_stb;
  logic              pix_tick;
  lps_state_t        state_reg;
  lps_state_t        state_next;
  logic [4:0]        gap_cnt_reg;
  logic [6:0]        qual_cnt_reg;
  logic [2:0]        slot_reg;
  logic [WORD_W-1:0] tx_word_reg;
  logic              pix_rst_src_reg;
  logic [LANES-1:0]  data_p_reg;
  logic [LANES-1:0]  data_n_reg;
  logic              data_oe_reg;
  logic              clk_p_reg;
  logic              clk_n_reg;
  logic              clk_oe_reg;
  logic              locked_reg;
  wire  [WORD_W-1:0] pix_word;
  wire               clock_dead;
  wire               qual_done;
  wire               tx_load;
  wire  [LANES-1:0]  lane_bit;
  wire               clk_bit;
  wire               drive_next;
  wire               run_next;
  wire  [LANES-1:0]  data_p_next;
  wire               clk_p_next;

  //////////////////////////////////////////////////////////////////////////
  // input word and capture; control lines ride in the word like colour bits
  assign pix_word = {spare_ctrl, pixel_valid, frame_sync, line_sync,
                     parallel_pixel_inputs};

  lps_word_cdc u_cdc (
    .pix_clk      (pixel_clock_input),
    .pix_rst_src  (pix_rst_src_reg),
    .edge_sel_pin (strobe_edge_select),
    .pix_word     (pix_word),
    .clk          (clk),
    .sys_rst      (sys_rst),
    .word_out     (cdc_word),
    .word_stb     (cdc_stb),
    .pix_tick     (pix_tick)
  );

  lps_sync2 #(.W(1)) u_sleep (
    .clk (clk),
    .rst (sys_rst),
    .d   (sleep_request_n),
    .q   (sleep_n_s)
  );

  //////////////////////////////////////////////////////////////////////////
  // clock activity monitor stands in for the loop's lock detector
  assign clock_dead = (gap_cnt_reg == MISS_CYCLES);
  assign qual_done  = (qual_cnt_reg == LOCK_QUAL_CYCLES);

  // gap count saturates, so a stopped clock is seen however long it stays off
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gap_cnt_reg <= MISS_CYCLES;
    end else if (pix_tick) begin
      gap_cnt_reg <= 5'h00;
    end else if (!clock_dead) begin
      gap_cnt_reg <= gap_cnt_reg + 5'h01;
    end
  end

  // qualification restarts once the clock is seen dead, so a clock that comes late still locks
  always_ff @(posedge clk) begin
    if (sys_rst || state_reg != ST_ACQUIRE || clock_dead) begin
      qual_cnt_reg <= 7'h00;
    end else if (!qual_done) begin
      qual_cnt_reg <= qual_cnt_reg + 7'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // lock state machine
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_SLEEP: begin
        if (sleep_n_s) state_next = ST_ACQUIRE;
      end
      ST_ACQUIRE: begin
        if (!sleep_n_s) state_next = ST_SLEEP;
        else if (qual_done) state_next = ST_LOCKED;
      end
      ST_LOCKED: begin
        if (!sleep_n_s) state_next = ST_SLEEP;
        else if (clock_dead) state_next = ST_ACQUIRE;
      end
    endcase
  end

  // sleep also holds the pixel-side logic in reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg       <= ST_SLEEP;
      pix_rst_src_reg <= 1'b1;
    end else begin
      state_reg       <= state_next;
      pix_rst_src_reg <= (state_next == ST_SLEEP);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // serializer: one frame of seven slots carries the latest delivered word;
  // the frame is free running, so input words arriving faster than one per
  // frame are thinned out rather than queued
  assign tx_load = (state_reg != ST_LOCKED) || (slot_reg == SLOT_LAST);

  always_ff @(posedge clk) begin
    if (sys_rst || state_reg != ST_LOCKED) begin
      slot_reg <= SLOT_FIRST;
    end else if (slot_reg == SLOT_LAST) begin
      slot_reg <= SLOT_FIRST;
    end else begin
      slot_reg <= slot_reg + 3'h1;
    end
  end

  // each frame takes whatever word arrived last, following any rate drift
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_word_reg <= '0;
    end else if (tx_load) begin
      tx_word_reg <= cdc_word;
    end
  end

  // lane k carries word bits 7k to 7k+6, lowest first
  genvar k;
  generate
    for (k = 0; k < LANES; k++) begin : g_lane
      wire [BITS_PER_LANE-1:0] lane_frame = tx_word_reg[k*BITS_PER_LANE +: BITS_PER_LANE];
      assign lane_bit[k] = lane_frame[slot_reg];
    end
  endgenerate

  assign clk_bit     = CLK_PATTERN[slot_reg];
  assign drive_next  = (state_next != ST_SLEEP);
  assign run_next    = (state_reg == ST_LOCKED) && (state_next == ST_LOCKED);
  // while acquiring the pairs are driven low rather than left floating
  assign data_p_next = run_next ? lane_bit : '0;
  assign clk_p_next  = run_next ? clk_bit : 1'b0;

  //////////////////////////////////////////////////////////////////////////
  // output flops; enables drop on the cycle the machine goes to sleep
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      data_p_reg  <= '0;
      data_n_reg  <= '0;
      data_oe_reg <= 1'b0;
      clk_p_reg   <= 1'b0;
      clk_n_reg   <= 1'b0;
      clk_oe_reg  <= 1'b0;
      locked_reg  <= 1'b0;
    end else begin
      data_p_reg  <= data_p_next;
      data_n_reg  <= drive_next ? ~data_p_next : '0;
      data_oe_reg <= drive_next;
      clk_p_reg   <= clk_p_next;
      clk_n_reg   <= drive_next ? ~clk_p_next : 1'b0;
      clk_oe_reg  <= drive_next;
      locked_reg  <= (state_next == ST_LOCKED);
    end
  end

  assign serial_data_pairs_p    = data_p_reg;
  assign serial_data_pairs_n    = data_n_reg;
  assign serial_data_oe         = data_oe_reg;
  assign forwarded_clock_pair_p = clk_p_reg;
  assign forwarded_clock_pair_n = clk_n_reg;
  assign forwarded_clock_oe     = clk_oe_reg;
  assign pll_locked             = locked_reg;

  //////////////////////////////////////////////////////////////////////////
  // helper counters read only by the checks below
  logic [3:0]  sleep_low_cnt;
  logic [23:0] acq_cnt;

  // counts on the synchronised level, so the two sync edges are already spent
  always_ff @(posedge clk) begin
    if (sys_rst || sleep_n_s) begin
      sleep_low_cnt <= 4'h0;
    end else if (sleep_low_cnt != 4'(SLEEP_ENTRY_CYCLES - 2)) begin
      sleep_low_cnt <= sleep_low_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || state_reg != ST_ACQUIRE || clock_dead) begin
      acq_cnt <= 24'h000000;
    end else begin
      acq_cnt <= acq_cnt + 24'h000001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_sleep_entry;
    @(posedge clk) disable iff (sys_rst)
      (sleep_low_cnt == 4'(SLEEP_ENTRY_CYCLES - 2)) |-> (!serial_data_oe && !forwarded_clock_oe);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("outputs still driven 100 ns after sleep request");

  property p_sleep_quiet;
    @(posedge clk) disable iff (sys_rst)
      (state_reg == ST_SLEEP) |-> (serial_data_pairs_p == '0 && !pll_locked
                                   && !forwarded_clock_pair_p);
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("outputs active while asleep");

  property p_sleep_reset;
    @(posedge clk) disable iff (sys_rst)
      (!sleep_n_s) |=> (state_reg == ST_SLEEP) && pix_rst_src_reg;
  endproperty
  a_sleep_reset: assert property (p_sleep_reset)
    else $error("sleep did not reset the lock logic");

  property p_lock_time;
    @(posedge clk) disable iff (sys_rst)
      (state_reg == ST_ACQUIRE) |-> (acq_cnt < LOCK_MAX_CYCLES);
  endproperty
  a_lock_time: assert property (p_lock_time)
    else $error("lock not reached within the lock time");

  property p_relock;
    @(posedge clk) disable iff (sys_rst)
      (state_reg == ST_LOCKED && clock_dead && sleep_n_s) |=> (state_reg == ST_ACQUIRE)
        ##[1:3] !pll_locked;
  endproperty
  a_relock: assert property (p_relock)
    else $error("stopped clock did not return the loop to acquire");

  property p_clock_pattern;
    @(posedge clk) disable iff (sys_rst)
      ($past(run_next) && !sys_rst) |-> (forwarded_clock_pair_p
                                         == CLK_PATTERN[$past(slot_reg)]);
  endproperty
  a_clock_pattern: assert property (p_clock_pattern)
    else $error("forwarded clock pattern out of step with the frame");

  property p_lane_map;
    @(posedge clk) disable iff (sys_rst)
      $past(run_next) |-> (serial_data_pairs_p[3] ==
                           $past(tx_word_reg[3*BITS_PER_LANE + int'(slot_reg)]));
  endproperty
  a_lane_map: assert property (p_lane_map)
    else $error("lane 3 bit does not match the word map");

  property p_pairs_differ;
    @(posedge clk) disable iff (sys_rst)
      (serial_data_oe && forwarded_clock_oe) |->
        ((serial_data_pairs_p ^ serial_data_pairs_n) == '1
         && forwarded_clock_pair_p != forwarded_clock_pair_n);
  endproperty
  a_pairs_differ: assert property (p_pairs_differ)
    else $error("differential pair not complementary while driven");

  property p_frame_load;
    @(posedge clk) disable iff (sys_rst)
      (state_reg == ST_LOCKED && slot_reg == SLOT_LAST && state_next == ST_LOCKED)
        |=> (tx_word_reg == $past(cdc_word)) && (slot_reg == SLOT_FIRST);
  endproperty
  a_frame_load: assert property (p_frame_load)
    else $error("frame did not take the latest word");

  c_locked: cover property (@(posedge clk) disable iff (sys_rst) $rose(pll_locked));
  c_sleep:  cover property (@(posedge clk) disable iff (sys_rst)
                            pll_locked ##1 !serial_data_oe);
  c_relock: cover property (@(posedge clk) disable iff (sys_rst)
                            $fell(pll_locked) && sleep_n_s);
  c_word:   cover property (@(posedge clk) disable iff (sys_rst) cdc_stb && pll_locked);
endmodule : lps_top

//--- src/lps_word_cdc.sv
// pixel clock capture and handshake crossing of the 28-bit input word
`timescale 1ns/1ps
module lps_word_cdc
  import lps_pkg::*;
(
  input  wire logic              pix_clk,      // pixel clock from the source
  input  wire logic              pix_rst_src,  // reset level from the system domain
  input  wire logic              edge_sel_pin, // strobe edge select pin, 1 = rising
  input  wire logic [WORD_W-1:0] pix_word,     // parallel input word
  input  wire logic              clk,          // system clock
  input  wire logic              sys_rst,      // system reset
  output logic      [WORD_W-1:0] word_out,     // last word delivered
  output logic                   word_stb,     // one-cycle pulse, word_out new
  output logic                   pix_tick      // pulse per seen pixel clock toggle
);
  logic              pix_rst;
  logic              edge_rise;
  logic              ack_s;
  logic              req_s;
  logic              alive_s;
  logic [WORD_W-1:0] neg_word_reg;
  logic [WORD_W-1:0] hold_reg;
  logic              req_reg;
  logic              alive_tgl_reg;
  logic              ack_reg;
  logic              alive_d_reg;
  logic [WORD_W-1:0] word_reg;
  logic              stb_reg;
  wire  [WORD_W-1:0] chosen_word;
  wire               take_word;
  wire               new_req;

  //////////////////////////////////////////////////////////////////////////
  // pixel domain
  lps_sync2 #(.W(1)) u_pix_rst (.clk(pix_clk), .rst(1'b0), .d(pix_rst_src), .q(pix_rst));
  lps_sync2 #(.W(1)) u_edge    (.clk(pix_clk), .rst(pix_rst), .d(edge_sel_pin), .q(edge_rise));
  lps_sync2 #(.W(1)) u_ack     (.clk(pix_clk), .rst(pix_rst), .d(ack_reg), .q(ack_s));

  // falling-edge copy, used when the select pin is low
  always_ff @(negedge pix_clk) begin
    neg_word_reg <= pix_word;
  end

  // rising edge samples the pins directly, falling edge uses the half-cycle copy
  assign chosen_word = edge_rise ? pix_word : neg_word_reg;
  assign take_word   = (ack_s == req_reg);

  // hold register is stable while a request is outstanding
  always_ff @(posedge pix_clk) begin
    if (pix_rst) begin
      hold_reg      <= '0;
      req_reg       <= 1'b0;
      alive_tgl_reg <= 1'b0;
    end else begin
      alive_tgl_reg <= ~alive_tgl_reg;
      if (take_word) begin
        hold_reg <= chosen_word;
        req_reg  <= ~req_reg;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // system domain
  lps_sync2 #(.W(1)) u_req   (.clk(clk), .rst(sys_rst), .d(req_reg), .q(req_s));
  lps_sync2 #(.W(1)) u_alive (.clk(clk), .rst(sys_rst), .d(alive_tgl_reg), .q(alive_s));

  assign new_req = (req_s != ack_reg);

  // word is copied only after the request toggle has settled through two stages
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_reg     <= 1'b0;
      word_reg    <= '0;
      stb_reg     <= 1'b0;
      alive_d_reg <= 1'b0;
    end else begin
      alive_d_reg <= alive_s;
      stb_reg     <= new_req;
      if (new_req) begin
        word_reg <= hold_reg;
        ack_reg  <= req_s;
      end
    end
  end

  assign word_out = word_reg;
  assign word_stb = stb_reg;
  assign pix_tick = alive_s ^ alive_d_reg;
endmodule : lps_word_cdc
